//--- include/anpd_pkg.sv
// package of the negotiation and parallel detect block: map, fields, states
package anpd_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BMC = 6'h00;
  localparam logic [5:0] IDX_BMS = 6'h01;
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LPA = 6'h05;
  localparam logic [5:0] IDX_EXP = 6'h06;
  localparam logic [5:0] IDX_SUM = 6'h10;
  // ==========================================================
  // control register fields
  localparam int BMC_SPEED = 13;
  localparam int BMC_AN_EN = 12;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX = 8;
  localparam logic [15:0] BMC_RESET = 16'h3100;
  // ability bits shared by advertisement and partner words
  localparam int AB_100FD = 8;
  localparam int AB_100HD = 7;
  localparam int AB_10FD = 6;
  localparam int AB_10HD = 5;
  localparam int AB_RF = 13;
  localparam int AB_NP = 15;
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [3:0] ADV_HALF_ONLY = 4'h5;
  localparam logic [3:0] ADV_ALL = 4'hf;
  localparam logic [15:0] ADV_WMASK = 16'ha1e0;
  localparam logic [15:0] LPA_PD_100 = 16'h0081;
  localparam logic [15:0] LPA_PD_10 = 16'h0021;
  // status: 100FD,100HD,10FD,10HD, preamble suppress, AN able, extended
  localparam logic [15:0] BMS_FIXED = 16'h7849;
  localparam int BMS_COMPLETE = 5;
  localparam int BMS_RFAULT = 4;
  localparam int BMS_LINK = 2;
  localparam int EXP_PDF = 4;
  localparam int EXP_LP_NP = 3;
  localparam int EXP_NP = 2;
  localparam int EXP_PAGE = 1;
  localparam int EXP_LP_AN = 0;
  localparam int SUM_LINK = 0;
  localparam int SUM_SPEED10 = 1;
  localparam int SUM_DUPLEX = 2;
  localparam int SUM_COMPLETE = 4;
  // ==========================================================
  // timing
  localparam longint BREAK_MS = 1500;
  localparam longint CLK_HZ = 20000000;
  localparam longint BREAK_CYC = BREAK_MS * CLK_HZ / 1000;
  // ==========================================================
  typedef enum logic [3:0] {
    ST_FORCED = 4'b0001,
    ST_BREAK = 4'b0010,
    ST_NEGO = 4'b0100,
    ST_DONE = 4'b1000
  } anpd_state_e;
  // link-facing inputs from the receivers and FLP decoder
  typedef struct packed {
    logic [15:0] page;
    logic page_valid;
    logic flp_seen;
    logic good10;
    logic good100;
  } anpd_rx_s;
  // link-facing outputs toward the transmitter
  typedef struct packed {
    logic [15:0] word;
    logic flp_en;
    logic halt;
    logic speed100;
    logic full_duplex;
    logic link_up;
  } anpd_tx_s;
endpackage : anpd_pkg

//--- hdl/anpd_core.sv
// negotiation control, parallel detection and register file with Wishbone slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// RQ1: strap sampled after reset sets advertisement bits 8:5
// RQ2: strap low half only, high half and full
// RQ3: software overrides strap via control register anytime
// RQ4: advertisement word sent in FLP bursts
// RQ5: resolve highest common mode, 100FD first
// RQ6: control register enables, disables, restarts negotiation
// RQ7: forced mode uses speed and duplex bits
// RQ8: speed and duplex ignored while negotiation enabled
// RQ9: status summary shows resolved speed after link
// RQ10: ability bits fixed, T4 reads clear
// RQ11: status shows complete, remote fault, link, preamble
// RQ12: advertisement defaults full, software may clear abilities
// RQ13: partner register captures base and next pages
// RQ14: parallel detect partner word 0081 or 0021
// RQ15: expansion flags fault, next pages, page, partner able
// RQ16: both receivers report link to negotiation
// RQ17: non-negotiating partner: adopt detected technology
// RQ18: partner-able reads zero after parallel detect
// RQ19: fault when both 10 and 100 links are good at once
// RQ20: restart bit or link loss restarts negotiation
// RQ21: restart halts link for break timer, then FLP
// RQ22: software toggles enable after forced power-up
// RQ23: advertisement changes apply at next (re)start
module anpd_core import anpd_pkg::*; #(
  parameter longint BREAK_CYCLES = BREAK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic negotiation_strap_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire anpd_rx_s rx_i,
  output anpd_tx_s tx_o
);
  // ==========================================================
  // whole state of the block
  typedef struct packed {
    anpd_state_e st;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] bmc;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic strap_pend;
    logic [31:0] tmr;
    logic pdf;
    logic page_rx;
    logic lp_an;
    logic lp_np;
    logic done;
    logic pd_done;
    logic link;
    anpd_tx_s tx;
  } anpd_st_s;

  anpd_st_s s_q;
  anpd_st_s s_d;
  logic [5:0] idx;
  logic acc;
  logic wr;
  logic [15:0] wv;
  logic [3:0] common;
  logic [15:0] bms;
  logic [15:0] exp_r;
  logic [15:0] sum;
  logic one_good;

  // ==========================================================
  // decode and read views
  assign idx = wb_adr_i[7:2];
  assign acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
  // write lands on the edge where the master sees ack
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;
  assign wv = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign common = s_q.tx.word[8:5] & s_q.lpa[8:5];
  assign one_good = rx_i.good10 ^ rx_i.good100; // [RQ16]
  // fixed abilities plus live status bits
  assign bms = BMS_FIXED | {10'h000, s_q.done, s_q.lpa[AB_RF] & ~s_q.pd_done, 1'b0, s_q.link, 2'b00}; // [RQ10] [RQ11]
  assign exp_r = {11'h000, s_q.pdf, s_q.lp_np, 1'b1, s_q.page_rx, s_q.lp_an}; // [RQ15]
  assign sum = {11'h000, s_q.done, 1'b0, s_q.tx.full_duplex, ~s_q.tx.speed100, s_q.link}; // [RQ9]

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.tx.halt = 1'b0;
    s_d.tx.flp_en = 1'b0;
    // read data captured with ack; unmapped reads as zero
    if (acc && !wb_we_i) begin
      unique case (idx)
        IDX_BMC: s_d.rdata = {16'h0000, s_q.bmc};
        IDX_BMS: s_d.rdata = {16'h0000, bms};
        IDX_ADV: s_d.rdata = {16'h0000, s_q.adv};
        IDX_LPA: s_d.rdata = {16'h0000, s_q.lpa};
        IDX_EXP: s_d.rdata = {16'h0000, exp_r};
        IDX_SUM: s_d.rdata = {16'h0000, sum};
        default: s_d.rdata = 32'h0000_0000;
      endcase
      // latched flags clear on read; a same-cycle set below still wins
      if (idx == IDX_EXP) begin
        s_d.pdf = 1'b0;
        s_d.page_rx = 1'b0;
      end
    end
    // strap applies one cycle after reset release
    if (s_q.strap_pend) begin
      s_d.strap_pend = 1'b0;
      s_d.adv[8:5] = negotiation_strap_i ? ADV_ALL : ADV_HALF_ONLY; // [RQ1] [RQ2]
    end
    if (wr && idx == IDX_ADV) begin
      s_d.adv = (s_q.adv & ~ADV_WMASK) | (wv & ADV_WMASK); // [RQ12]
    end
    // restart bit lives one cycle so the override below can see it
    s_d.bmc[BMC_RESTART] = 1'b0; // self clearing
    if (wr && idx == IDX_BMC) begin
      s_d.bmc = wv; // [RQ3] [RQ6] [RQ20]
    end
    // link status follows the receivers
    s_d.link = s_q.done & (s_q.tx.speed100 ? rx_i.good100 : rx_i.good10);
    unique case (s_q.st)
      ST_FORCED: begin
        // forced mode: control bits pick the mode
        s_d.tx.speed100 = s_q.bmc[BMC_SPEED]; // [RQ7]
        s_d.tx.full_duplex = s_q.bmc[BMC_DUPLEX]; // [RQ7]
        s_d.link = s_q.bmc[BMC_SPEED] ? rx_i.good100 : rx_i.good10;
        s_d.done = 1'b0;
        // only a fresh set of enable starts negotiation
        if (wr && idx == IDX_BMC && wv[BMC_AN_EN] && !s_q.bmc[BMC_AN_EN]) begin // [RQ22]
          s_d.st = ST_BREAK;
          s_d.tmr = 32'h0000_0000;
          // a restart written with the enable is already served here
          s_d.bmc[BMC_RESTART] = 1'b0;
        end
      end
      ST_BREAK: begin
        s_d.tx.halt = 1'b1; // [RQ21]
        s_d.tmr = s_q.tmr + 32'h0000_0001;
        if (s_q.tmr >= 32'(BREAK_CYCLES - 1)) begin
          s_d.st = ST_NEGO;
          s_d.tx.word = s_q.adv; // [RQ23]
          s_d.lp_an = 1'b0;
          s_d.lp_np = 1'b0;
          s_d.pd_done = 1'b0;
        end
      end
      ST_NEGO: begin
        s_d.tx.flp_en = 1'b1; // [RQ4]
        s_d.done = 1'b0;
        if (rx_i.page_valid) begin
          // base page and next pages all land here
          s_d.lpa = rx_i.page; // [RQ13]
          s_d.page_rx = 1'b1;
          s_d.lp_an = 1'b1;
          s_d.lp_np = rx_i.page[AB_NP];
        end else if (s_q.lp_an && !s_q.lpa[AB_NP] && common != 4'h0) begin
          // resolve by priority
          s_d.st = ST_DONE;
          s_d.done = 1'b1;
          s_d.tx.speed100 = common[3] | common[2]; // [RQ5] [RQ8]
          s_d.tx.full_duplex = common[3] | (~common[2] & common[1]); // [RQ5]
        end else if (!rx_i.flp_seen && !s_q.lp_an) begin
          if (one_good) begin
            // partner does not negotiate: adopt its technology
            s_d.st = ST_DONE;
            s_d.done = 1'b1;
            s_d.pd_done = 1'b1;
            s_d.tx.speed100 = rx_i.good100; // [RQ17]
            s_d.tx.full_duplex = 1'b0;
            s_d.lpa = rx_i.good100 ? LPA_PD_100 : LPA_PD_10; // [RQ14]
            s_d.lp_an = 1'b0; // [RQ18]
          end else if (rx_i.good10 && rx_i.good100) begin
            s_d.pdf = 1'b1; // [RQ19]
          end
        end
      end
      ST_DONE: begin
        // losing link after success resumes negotiation directly
        if (!(s_q.tx.speed100 ? rx_i.good100 : rx_i.good10)) begin // [RQ20]
          s_d.st = ST_NEGO;
          s_d.done = 1'b0;
          s_d.tx.word = s_q.adv;
        end
      end
    endcase
    // management restart or disable override the sequence
    if (s_q.st != ST_FORCED) begin
      if (!s_q.bmc[BMC_AN_EN]) begin
        s_d.st = ST_FORCED;
      end else if (s_q.bmc[BMC_RESTART]) begin // [RQ20] [RQ21]
        s_d.st = ST_BREAK;
        s_d.tmr = 32'h0000_0000;
        s_d.done = 1'b0;
      end
    end
    s_d.tx.link_up = s_d.link;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_NEGO;
      s_q.bmc <= BMC_RESET;
      s_q.adv <= ADV_RESET;
      s_q.strap_pend <= 1'b1;
      s_q.tx.word <= ADV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign tx_o = s_q.tx;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_strap_loads_adv: assert property (s_q.strap_pend |=>
    s_q.adv[8:5] == ($past(negotiation_strap_i) ? 4'hf : 4'h5)) // [RQ1]
    else $error("strap not applied");
  a_break_halts_link: assert property (s_q.st == ST_BREAK && s_q.tmr > 32'h1 |-> tx_o.halt && !tx_o.flp_en) // [RQ21]
    else $error("link active during break");
  a_forced_follows_bits: assert property (s_q.st == ST_FORCED ##1 s_q.st == ST_FORCED |->
    tx_o.speed100 == $past(s_q.bmc[BMC_SPEED]) && tx_o.full_duplex == $past(s_q.bmc[BMC_DUPLEX])) // [RQ7]
    else $error("forced mode ignores control");
  a_word_held_nego: assert property (s_q.st == ST_NEGO && $past(s_q.st) == ST_NEGO |-> $stable(tx_o.word)) // [RQ23]
    else $error("advertised word changed mid exchange");
  a_pd_partner_word: assert property ($rose(s_q.pd_done) |->
    (s_q.lpa == 16'h0081 && tx_o.speed100) || (s_q.lpa == 16'h0021 && !tx_o.speed100)) // [RQ14]
    else $error("bad parallel detect word");
  a_pd_not_able: assert property (s_q.done && s_q.pd_done |-> !exp_r[EXP_LP_AN]) // [RQ18]
    else $error("partner able after parallel detect");
  a_t4_clear: assert property (!bms[15] && bms[14:11] == 4'hf) // [RQ10]
    else $error("ability bits wrong");
  a_pick_100fd: assert property ($rose(s_q.done) && !s_q.pd_done && $past(common[3]) |->
    tx_o.speed100 && tx_o.full_duplex) // [RQ5]
    else $error("priority resolution wrong");
  a_pdf_on_two: assert property (s_q.st == ST_NEGO && !rx_i.flp_seen && !s_q.lp_an && rx_i.good10 &&
    rx_i.good100 && s_q.bmc[BMC_AN_EN] && !s_q.bmc[BMC_RESTART] |=> s_q.pdf) // [RQ19]
    else $error("parallel fault missed");
endmodule : anpd_core

//--- tb/anpd_partner.sv
// remote link partner model: sends code words in FLP or plain link signals
`timescale 1ns/100ps
module anpd_partner import anpd_pkg::*; (
  input wire logic clk_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] word_i,
  input wire anpd_tx_s tx_i,
  output anpd_rx_s rx_o
);
  // mode 0 silent, 1 negotiating, 2 good 10, 3 good 100, 4 both good
  logic [1:0] cnt;
  initial begin
    rx_o = '0;
    cnt = 2'h0;
  end
  // ==========================================================
  // link side
  // a page is only offered while our bursts run, as a real partner would
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    rx_o.page_valid <= 1'b0;
    rx_o.flp_seen <= (mode_i == 3'h1) && tx_i.flp_en;
    // a negotiating partner shows link of the best common speed
    rx_o.good10 <= (mode_i == 3'h2) || (mode_i == 3'h4) ||
      (mode_i == 3'h1 && ~|(word_i[8:7] & tx_i.word[8:7]));
    rx_o.good100 <= (mode_i == 3'h3) || (mode_i == 3'h4) ||
      (mode_i == 3'h1 && |(word_i[8:7] & tx_i.word[8:7]));
    if (mode_i == 3'h1 && tx_i.flp_en && cnt == 2'h0) begin
      rx_o.page <= word_i;
      rx_o.page_valid <= 1'b1;
    end else begin
      rx_o.page <= ~rx_o.page; // idle lines must not hold the last word
    end
  end
endmodule : anpd_partner

//--- tb/anpd_core_tb.sv
// bench of the negotiation block: bus tasks, mode model and scenarios
`timescale 1ns/100ps
module anpd_core_tb import anpd_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  anpd_rx_s rx;
  anpd_tx_s tx;
  logic [2:0] pm = 3'h0;
  logic [15:0] pw = 16'h0;
  logic [15:0] q;
  logic [1:0] m;
  int n_fail = 0;
  int n_checks = 0;
  int a, p, rf;
  always #25 clk_i = ~clk_i;
  anpd_core #(.BREAK_CYCLES(20)) anpd_core_i (.clk_i(clk_i), .rst_i(rst_i), .negotiation_strap_i(strap),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_i(rx), .tx_o(tx));
  anpd_partner anpd_partner_i (.clk_i(clk_i), .mode_i(pm), .word_i(pw), .tx_i(tx), .rx_o(rx));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // classic cycle held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [5:0] ix, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {16'h0, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) n_fail++;
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // highest common mode, {speed100, full duplex}
  function automatic logic [1:0] best(input int c);
    if (c & 8) return 2'b11;
    if (c & 4) return 2'b10;
    if (c & 2) return 2'b01;
    return 2'b00;
  endfunction : best
  // start negotiation and time the quiet period
  task automatic go(input logic [15:0] c);
    int n;
    n = 0;
    wb(1'b1, IDX_BMC, c);
    while (tx.halt !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (tx.halt === 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("break", 16'(n), 16'd20);
    chk("flp", tx.flp_en, 1'b1);
  endtask : go
  // polls status, bounded
  task automatic done;
    int n;
    n = 0;
    do begin
      wb(1'b0, IDX_BMS, 16'h0);
      n++;
    end while (q[BMS_COMPLETE] !== 1'b1 && n < 20);
    if (q[BMS_COMPLETE] !== 1'b1) n_fail++;
  endtask : done
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // watchdog, about forty times the expected run
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(16371));
    strap = 1'($urandom_range(1, 0));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, IDX_ADV, 16'h0);
    chk("adv", q, strap ? 16'h01e1 : 16'h00a1);
    wb(1'b0, IDX_BMC, 16'h0);
    chk("ctl", q, BMC_RESET);
    wb(1'b0, IDX_BMS, 16'h0);
    chk("bms", q & 16'hffcb, BMS_FIXED);
    wb(1'b1, 6'h02, 16'hffff);
    wb(1'b0, 6'h02, 16'h0);
    chk("unmapped", q, 16'h0);
    // forced speed and duplex from control bits
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, IDX_BMC, {2'b0, i[1], 4'b0, i[0], 8'h0});
      repeat (2) @(posedge clk_i);
      wb(1'b0, IDX_SUM, 16'h0);
      chk("fsum", q & 16'h0006, 16'(i[0] << 2 | !i[1] << 1));
      chk("fspd", tx.speed100, i[1]);
      chk("fdup", tx.full_duplex, i[0]);
    end
    // negotiated runs, random abilities; enable toggled from forced first
    repeat (6) begin
      a = $urandom_range(15, 1);
      p = $urandom_range(15, 1);
      if ((a & p) == 0) p = a;
      rf = $urandom_range(1, 0);
      wb(1'b1, IDX_ADV, 16'(a << 5 | 1));
      wb(1'b0, IDX_ADV, 16'h0);
      chk("advw", q, 16'(a << 5 | 1));
      pm <= 3'h0;
      go(16'h1200 | (16'h2100 & 16'($urandom())));
      chk("word", tx.word, 16'(a << 5 | 1));
      pw <= 16'(p << 5 | rf << 13 | 1);
      pm <= 3'h1;
      done();
      m = best(a & p);
      chk("spd", tx.speed100, m[1]);
      chk("dup", tx.full_duplex, m[0]);
      wb(1'b0, IDX_LPA, 16'h0);
      chk("lpa", q, pw);
      wb(1'b0, IDX_BMS, 16'h0);
      chk("bmsn", q & 16'hfffb, BMS_FIXED | 16'h0020 | 16'(rf << 4));
      wb(1'b0, IDX_SUM, 16'h0);
      chk("sum", q & 16'h0016, 16'(16 | m[0] << 2 | !m[1] << 1));
      wb(1'b0, IDX_EXP, 16'h0);
      chk("exp", q & 16'h0013, 16'h0003);
    end
    // parallel detection: 10 only, 100 only, both good
    for (int k = 2; k < 5; k++) begin
      pm <= 3'h0;
      go(16'h1200);
      pm <= 3'(k);
      if (k == 4) repeat (10) @(posedge clk_i);
      else done();
      wb(1'b0, IDX_EXP, 16'h0);
      if (k == 4) begin
        chk("pdf", q & 16'h0010, 16'h0010);
      end else begin
        chk("pexp", q & 16'h0011, 16'h0000);
        wb(1'b0, IDX_LPA, 16'h0);
        chk("plpa", q, k == 3 ? LPA_PD_100 : LPA_PD_10);
        chk("pspd", tx.speed100, k == 3);
        chk("pdup", tx.full_duplex, 1'b0);
        pm <= 3'h0;
        for (int n = 0; n < 20 && tx.flp_en !== 1'b1; n++) @(posedge clk_i);
        chk("loss", tx.flp_en, 1'b1);
      end
    end
    end_of_test();
  end
endmodule : anpd_core_tb
